// File: mbw_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module mbw_far_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Write requests
    input wire logic i_wr_valid,
    input wire mbw_pkg::mbw_wr_type i_wr,
    // Answers
    output logic o_tx_ready,
    output logic o_wr_reject
);
    import mbw_pkg::*;
    logic [2:0] cnt_ff;
    // Stall one cycle in four
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= 3'h0;
            o_tx_ready <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
            o_tx_ready <= cnt_ff[1:0] != 2'h3;
        end
    end
    // Reject answer stands during the write pulse; noise otherwise
    always_comb begin
        o_wr_reject = i_wr_valid ? (i_wr.data == 16'hbad0) : cnt_ff[0];
    end
endmodule
`default_nettype wire

// File: mbw_handler.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Function 06h stores one 16-bit value at the register address given.
// - A single write query is address, function, reg addr hi/lo, value hi/lo, CRC.
// - Every frame ends with a CRC-16 over the prior bytes, low byte first.
// - Function 08h echoes arbitrary test data back to the master.
// - Diagnosis supports only sub-function 0000h; others are unsupported.
// - The diagnosis answer repeats the query byte for byte, CRC included.
// - Function 10h writes consecutive registers, at most 16 per query.
// - A multiple write commits registers one by one in ascending order.
// - Registers written before a rejected value may remain written.
// - A multiple write query is start, count, byte count, values hi first, CRC.
// - The byte count of a multiple write equals twice the register count.
// - The multiple write answer copies address, function, start and count.
// - A register count of zero or above the maximum gives invalid data.
// - A byte count not twice the register count gives invalid data.
// - Register addresses outside the supported range give invalid address.
module mbw_handler #(
    parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Received frame bytes
    input wire logic i_rx_valid,
    input wire mbw_pkg::mbw_beat_type i_rx_beat,
    // Response bytes
    output logic o_tx_valid,
    output mbw_pkg::mbw_beat_type o_tx_beat,
    input wire logic i_tx_ready,
    // Register write port
    output logic o_wr_valid,
    output mbw_pkg::mbw_wr_type o_wr,
    input wire logic i_wr_reject
);
    import mbw_pkg::*;

    logic [7:0] buf_ff [FRAME_MAX];
    logic [5:0] len_ff;
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    mbw_state_type state_ff;
    logic [4:0] idx_ff;
    logic [5:0] out_len_ff;
    logic [5:0] out_idx_ff;
    logic calc_crc_ff;
    logic o_tx_valid_ff;
    mbw_beat_type o_tx_beat_ff;
    logic o_wr_valid_ff;
    mbw_wr_type o_wr_ff;
    logic [15:0] reg_addr;
    logic [15:0] reg_cnt;
    logic [16:0] addr_end;
    logic [7:0] nxt_exc;
    logic [7:0] in_byte;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign reg_addr = {buf_ff[2], buf_ff[3]};
    assign reg_cnt = {buf_ff[4], buf_ff[5]};
    assign addr_end = {1'b0, reg_addr} + {1'b0, reg_cnt};

    // Query validation, exception code or zero
    always_comb begin
        nxt_exc = 8'h00;
        case (buf_ff[1])
            FC_WRITE_ONE: begin
                if (reg_addr >= ADDR_LIMIT) nxt_exc = EXC_ADDR;
            end
            FC_DIAG: begin
                if (buf_ff[2] != DIAG_SUB_ECHO ||
                    buf_ff[3] != DIAG_SUB_ECHO) begin
                    nxt_exc = EXC_FUNC;
                end
            end
            FC_WRITE_MANY: begin
                if (reg_cnt == 16'h0000 || reg_cnt > 16'(MAX_REGS)) begin
                    nxt_exc = EXC_DATA;
                end else if ({8'h00, buf_ff[6]} != {reg_cnt[14:0], 1'b0}) begin
                    nxt_exc = EXC_DATA;
                end else if (addr_end > {1'b0, ADDR_LIMIT}) begin
                    nxt_exc = EXC_ADDR;
                end
            end
            default: nxt_exc = EXC_FUNC;
        endcase
    end

    assign in_byte = i_rx_beat.data;
    assign nxt_crc = crc_step(crc_ff, o_tx_beat_ff.data);

    // Frame receive, check, write and respond sequence
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= ST_RECV;
            len_ff <= 6'h00;
            idx_ff <= 5'h00;
            out_len_ff <= 6'h00;
            out_idx_ff <= 6'h00;
            calc_crc_ff <= 1'b0;
            crc_ff <= CRC_INIT;
            o_tx_valid_ff <= 1'b0;
            o_tx_beat_ff <= '0;
            o_wr_valid_ff <= 1'b0;
            o_wr_ff <= '0;
            for (int i = 0; i < FRAME_MAX; i++) buf_ff[i] <= 8'h00;
        end else begin
            o_wr_valid_ff <= 1'b0;
            case (state_ff)
                ST_RECV: begin
                    if (i_rx_valid) begin
                        if (len_ff < 6'(FRAME_MAX)) begin
                            buf_ff[len_ff] <= in_byte;
                            crc_ff <= crc_step(crc_ff, in_byte);
                            len_ff <= len_ff + 6'h01;
                        end
                        if (i_rx_beat.last) state_ff <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // Bad CRC, short frame or other slave: drop silently
                    if (crc_ff != 16'h0000 || len_ff < 6'd8 ||
                        buf_ff[0] != SLAVE_ADDR) begin
                        state_ff <= ST_RECV;
                    end else if (nxt_exc != 8'h00) begin
                        buf_ff[1] <= buf_ff[1] | EXC_FLAG;
                        buf_ff[2] <= nxt_exc;
                        out_len_ff <= 6'd3;
                        calc_crc_ff <= 1'b1;
                        state_ff <= ST_RESP;
                    end else if (buf_ff[1] == FC_DIAG) begin
                        out_len_ff <= 6'd8;
                        calc_crc_ff <= 1'b0;
                        state_ff <= ST_RESP;
                    end else begin
                        idx_ff <= 5'h00;
                        state_ff <= ST_WRITE;
                    end
                    crc_ff <= CRC_INIT;
                    // Dropped frames must not leave bytes behind
                    len_ff <= 6'h00;
                    out_idx_ff <= 6'h00;
                end
                ST_WRITE: begin
                    if (o_wr_valid_ff && i_wr_reject) begin
                        // Earlier registers stay written
                        buf_ff[1] <= buf_ff[1] | EXC_FLAG;
                        buf_ff[2] <= EXC_DATA;
                        out_len_ff <= 6'd3;
                        calc_crc_ff <= 1'b1;
                        state_ff <= ST_RESP;
                    end else if (buf_ff[1] == FC_WRITE_ONE) begin
                        if (!o_wr_valid_ff) begin
                            o_wr_valid_ff <= 1'b1;
                            o_wr_ff <= {reg_addr, buf_ff[4], buf_ff[5]};
                        end else begin
                            out_len_ff <= 6'd8;
                            calc_crc_ff <= 1'b0;
                            state_ff <= ST_RESP;
                        end
                    end else if (!o_wr_valid_ff &&
                                 {11'h000, idx_ff} < reg_cnt) begin
                        o_wr_valid_ff <= 1'b1;
                        o_wr_ff.addr <= reg_addr + {11'h000, idx_ff};
                        o_wr_ff.data <= {buf_ff[6'd7 + {idx_ff, 1'b0}],
                                         buf_ff[6'd8 + {idx_ff, 1'b0}]};
                        idx_ff <= idx_ff + 5'h01;
                    end else if (!o_wr_valid_ff) begin
                        out_len_ff <= 6'd6;
                        calc_crc_ff <= 1'b1;
                        state_ff <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    o_tx_valid_ff <= 1'b1;
                    o_tx_beat_ff.data <= buf_ff[0];
                    o_tx_beat_ff.last <= 1'b0;
                    out_idx_ff <= 6'h01;
                    state_ff <= ST_SEND;
                end
                ST_SEND: begin
                    if (i_tx_ready) begin
                        crc_ff <= nxt_crc;
                        if (o_tx_beat_ff.last) begin
                            o_tx_valid_ff <= 1'b0;
                            len_ff <= 6'h00;
                            crc_ff <= CRC_INIT;
                            state_ff <= ST_RECV;
                        end else if (calc_crc_ff &&
                                     out_idx_ff == out_len_ff) begin
                            o_tx_beat_ff.data <= nxt_crc[7:0];
                            out_idx_ff <= out_idx_ff + 6'h01;
                        end else if (calc_crc_ff &&
                                     out_idx_ff > out_len_ff) begin
                            o_tx_beat_ff.data <= crc_ff[15:8];
                            o_tx_beat_ff.last <= 1'b1;
                        end else begin
                            // Echo path copies stored CRC bytes too
                            o_tx_beat_ff.data <= buf_ff[out_idx_ff];
                            o_tx_beat_ff.last <= !calc_crc_ff &&
                                out_idx_ff == out_len_ff - 6'h01;
                            out_idx_ff <= out_idx_ff + 6'h01;
                        end
                    end
                end
                default: state_ff <= ST_RECV;
            endcase
        end
    end

    assign o_tx_valid = o_tx_valid_ff;
    assign o_tx_beat = o_tx_beat_ff;
    assign o_wr_valid = o_wr_valid_ff;
    assign o_wr = o_wr_ff;
endmodule
`default_nettype wire

// File: mbw_handler_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mbw_handler_bench;
    import mbw_pkg::*;
    localparam logic [7:0] SA = 8'h02;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_rx_valid = 1'b0;
    mbw_beat_type i_rx_beat = '0;
    logic o_tx_valid, i_tx_ready, o_wr_valid, i_wr_reject;
    mbw_beat_type o_tx_beat;
    mbw_wr_type o_wr;
    logic [15:0] lf = 16'h000f;
    logic [15:0] d;
    int num_errors = 0;
    int comparisons = 0;
    logic [8:0] exp_tx[$];
    logic [31:0] exp_wr[$];
    logic [7:0] q[$];
    always #5 i_mclk = ~i_mclk;
    mbw_handler #(.SLAVE_ADDR(SA)) mbw_handler_inst (.i_mclk(i_mclk),
        .i_rst_b(i_rst_b), .i_rx_valid(i_rx_valid), .i_rx_beat(i_rx_beat),
        .o_tx_valid(o_tx_valid), .o_tx_beat(o_tx_beat), .i_tx_ready(i_tx_ready),
        .o_wr_valid(o_wr_valid), .o_wr(o_wr), .i_wr_reject(i_wr_reject));
    mbw_far_model mbw_far_model_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_wr_valid(o_wr_valid), .i_wr(o_wr), .o_tx_ready(i_tx_ready),
        .o_wr_reject(i_wr_reject));
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Queue expected answer bytes, check bytes low first
    task automatic resp(input logic [7:0] r[$]);
        logic [15:0] c;
        c = crc(r);
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        foreach (r[i]) exp_tx.push_back({r[i], i == r.size() - 1});
    endtask
    // Send query with its check bytes, then wait for the answer
    task automatic send(input logic bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            i_rx_valid <= 1'b1;
            i_rx_beat <= {q[i], i == q.size() - 1};
            @(posedge i_mclk);
        end
        i_rx_valid <= 1'b0;
        for (int t = 0; t < 400 && exp_tx.size() > 0; t++) @(posedge i_mclk);
        if (exp_tx.size() > 0 || exp_wr.size() > 0) begin
            num_errors++;
            results();
        end
        repeat (30) @(posedge i_mclk);
    endtask
    task automatic mw(logic [15:0] a, logic [15:0] n, logic [7:0] bc,
                      logic [7:0] exc, int bad);
        logic [15:0] v;
        q = {SA, FC_WRITE_MANY, a[15:8], a[7:0], n[15:8], n[7:0], bc};
        for (int i = 0; i < n && i < 16; i++) begin
            v = (i == bad) ? 16'hbad0 : rnd() & 16'h7fff;
            q.push_back(v[15:8]);
            q.push_back(v[7:0]);
            if (exc == 8'h00 && (bad < 0 || i <= bad))
                exp_wr.push_back({a + 16'(i), v});
        end
        if (exc == 8'h00 && bad < 0)
            resp({SA, FC_WRITE_MANY, a[15:8], a[7:0], n[15:8], n[7:0]});
        else resp({SA, FC_WRITE_MANY | EXC_FLAG, bad < 0 ? exc : EXC_DATA});
        send(1'b0);
    endtask
    // Compare every answer byte and every write request
    always @(posedge i_mclk) begin
        if (o_tx_valid && i_tx_ready && exp_tx.size() == 0) cmp("tx extra", 0, 1);
        else if (o_tx_valid && i_tx_ready) cmp("tx", exp_tx.pop_front(), o_tx_beat);
        if (o_wr_valid && exp_wr.size() == 0) cmp("wr extra", 0, 1);
        else if (o_wr_valid) cmp("wr", exp_wr.pop_front(), o_wr);
    end
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(posedge i_mclk);
        q = {SA, FC_WRITE_ONE, 8'h02, 8'h4b, 8'h00, 8'h50};
        cmp("crc", 16'h6bf8, crc(q));
        exp_wr.push_back(32'h024b0050);
        resp(q);
        send(1'b0);
        d = rnd();
        q = {SA, FC_DIAG, DIAG_SUB_ECHO, DIAG_SUB_ECHO, d[15:8], d[7:0]};
        resp(q);
        send(1'b0);
        q = {SA, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34};
        resp({SA, FC_DIAG | EXC_FLAG, EXC_FUNC});
        send(1'b0);
        q = {SA, FC_WRITE_ONE, 8'h20, 8'h00, 8'h00, 8'h01};
        resp({SA, FC_WRITE_ONE | EXC_FLAG, EXC_ADDR});
        send(1'b0);
        q = {SA, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
        resp({SA, 8'h85, EXC_FUNC});
        send(1'b0);
        q = {SA, FC_WRITE_ONE, 8'h00, 8'h10, 8'h00, 8'h01};
        send(1'b1);
        q = {8'h07, FC_WRITE_ONE, 8'h00, 8'h10, 8'h00, 8'h01};
        send(1'b0);
        // Even counts and starts keep both halves together
        for (int j = 0; j < 3; j++) begin
            d = rnd();
            mw({4'h0, d[11:4], 4'h0}, {13'h0, d[2:1], 1'b0} + 16'h2,
               {5'h0, d[2:1], 2'h0} + 8'h4, 8'h00, -1);
        end
        mw(16'h0000, 16'h0010, 8'h20, 8'h00, -1);
        mw(16'h0000, 16'h0011, 8'h22, EXC_DATA, -1);
        mw(16'h0000, 16'h0000, 8'h00, EXC_DATA, -1);
        mw(16'h0040, 16'h0002, 8'h03, EXC_DATA, -1);
        mw(16'h1fff, 16'h0002, 8'h04, EXC_ADDR, -1);
        mw(16'h0100, 16'h0003, 8'h06, 8'h00, 1);
        results();
    end
endmodule
bind mbw_handler mbw_monitor mbw_monitor_inst (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_rx_valid(i_rx_valid), .i_rx_beat(i_rx_beat),
    .o_tx_valid(o_tx_valid), .o_tx_beat(o_tx_beat), .i_tx_ready(i_tx_ready),
    .o_wr_valid(o_wr_valid), .o_wr(o_wr), .i_wr_reject(i_wr_reject));
`default_nettype wire

// File: mbw_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mbw_monitor (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Streams
    input wire logic i_rx_valid,
    input wire mbw_pkg::mbw_beat_type i_rx_beat,
    input wire logic o_tx_valid,
    input wire mbw_pkg::mbw_beat_type o_tx_beat,
    input wire logic i_tx_ready,
    // Write port
    input wire logic o_wr_valid,
    input wire mbw_pkg::mbw_wr_type o_wr,
    input wire logic i_wr_reject
);
    import mbw_pkg::*;
    logic [5:0] n_ff;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // Bytes taken so far in this response
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            n_ff <= 6'h0;
        end else if (o_tx_valid && i_tx_ready) begin
            n_ff <= o_tx_beat.last ? 6'h0 : n_ff + 6'h1;
        end
    end
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_beat)) else $error("tx byte moved");
    chk_resp_len: assert property (o_tx_valid && i_tx_ready &&
        o_tx_beat.last |-> n_ff == 6'h4 || n_ff == 6'h7)
        else $error("response length wrong");
    chk_resp_end: assert property (o_tx_valid && i_tx_ready &&
        o_tx_beat.last |=> !o_tx_valid) else $error("tx after last");
    chk_wr_spacing: assert property (o_wr_valid |=> !o_wr_valid)
        else $error("writes too close");
    chk_wr_ascend: assert property (o_wr_valid ##2 o_wr_valid |->
        o_wr.addr == $past(o_wr.addr, 2) + 16'h1) else $error("not ascending");
    chk_wr_range: assert property (o_wr_valid |-> o_wr.addr < ADDR_LIMIT)
        else $error("write address out of range");
    chk_reject_stop: assert property (o_wr_valid && i_wr_reject |=>
        !o_wr_valid [*2]) else $error("write after reject");
    chk_wr_quiet: assert property (o_wr_valid |-> !o_tx_valid)
        else $error("write during response");
    chk_rx_settle: assert property (i_rx_valid && i_rx_beat.last &&
        !o_tx_valid |=> !o_tx_valid [*2]) else $error("answer before check");
endmodule
`default_nettype wire

// File: mbw_pkg.sv
package mbw_pkg;
    // Function codes
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [7:0] DIAG_SUB_ECHO = 8'h00;
    // Exception codes and flag
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_DATA = 8'h03;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    // Limits
    localparam int MAX_REGS = 16;
    localparam logic [15:0] ADDR_LIMIT = 16'h2000;
    localparam int FRAME_MAX = 41;
    // CRC-16
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    // Byte stream beat
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mbw_beat_type;

    // Register write request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mbw_wr_type;

    typedef enum logic [2:0] {
        ST_RECV = 3'b000,
        ST_CHECK = 3'b001,
        ST_WRITE = 3'b010,
        ST_RESP = 3'b011,
        ST_SEND = 3'b100
    } mbw_state_type;
endpackage
